// >>> hw/cct_host.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - host forms code as two's-complement ppm*2^20/10^6 plus 0x020
// - alarm minute is BCD 00..59, bit 7 zero; bad value never matches
// - alarm hour is BCD 00..23, or 01..12 and 21..32 in 12-hour mode
// - start: unlock, clear run, wait 2 sub-clocks, then configure
// - after run set, wait 2 sub-clocks before HALT or STOP
// - that wait is moot once the first tick or alarm interrupt came
// - host releases hold within 1 second of requesting it
// - host sees hold acknowledge low before entering STOP
// - unlock stays low except while accessing clock registers
// - alarm-safe read: mask, 1 s period, clear, wait tick, hold read, restore
// - before run, clear both request flags and both mask flags
module cct_host
	import cct_pkg::*;
#(
	parameter int SUBCLK_WAIT_CYC = CCT_SUBCLK_WAIT_CYC,
	parameter int HOLD_MAX_CYC = CCT_HOLD_MAX_CYC
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// user command port
	input wire logic cmd_valid,
	input wire logic [2:0] cmd_code,
	input wire logic twelve_hour,
	input wire logic [55:0] time_in,
	input wire logic [7:0] alarm_minute,
	input wire logic [7:0] alarm_hour,
	input wire logic [7:0] alarm_weekdays,
	input wire logic trim_on,
	input wire logic [8:0] trim_ppm_code,
	output logic busy,
	output logic done,
	output logic error,
	output logic alarm_hit,
	output logic stop_safe,
	output logic [55:0] time_out,
	// device register access
	output logic [19:0] dev_addr,
	output logic [15:0] dev_wdata,
	output logic dev_wr,
	output logic dev_rd,
	input wire logic [15:0] dev_rdata,
	input wire logic dev_ack
);

	////////////////////////////////////////////////////////////////////////////////
	// sequence landmarks of the read command
	localparam logic [5:0] READ_HOLD = 6'd9;
	localparam logic [5:0] READ_FIRST_TIME = 6'd11;
	localparam logic [5:0] READ_LAST_TIME = 6'd17;
	localparam logic [5:0] READ_RELEASE = 6'd18;
	localparam logic [5:0] READ_LOCK = 6'd24;

	typedef struct packed {
		cct_state_t state;
		cct_cmd_t cmd;
		logic [5:0] step;
		logic [27:0] wait_cnt;
		logic [27:0] hold_cnt;
		logic holding;
		logic running;
		logic alarm_armed;
		logic [19:0] dev_addr;
		logic [15:0] dev_wdata;
		logic dev_wr;
		logic dev_rd;
		logic busy;
		logic done;
		logic error;
		logic alarm_hit;
		logic stop_safe;
		logic [55:0] time_out;
	} cct_ctl_t;

	cct_ctl_t r;
	cct_ctl_t next_r;
	cct_op_t op;
	logic alarm_ok;

	cct_alarm_check i_cct_alarm_check (
		.alarm_minute(alarm_minute),
		.alarm_hour(alarm_hour),
		.alarm_weekdays(alarm_weekdays),
		.twelve_hour(twelve_hour),
		.alarm_ok(alarm_ok)
	);

	////////////////////////////////////////////////////////////////////////////////
	// operation builders
	function automatic cct_op_t op_mk(input cct_opk_t k, input logic [19:0] a,
		input logic [15:0] d, input int b, input logic v, input logic [2:0] s);
		op_mk.kind = k;
		op_mk.addr = a;
		op_mk.data = d;
		op_mk.bit_sel = 4'(b);
		op_mk.bit_val = v;
		op_mk.slot = s;
	endfunction

	function automatic cct_op_t op_wr(input logic [19:0] a, input logic [15:0] d);
		op_wr = op_mk(CCT_OP_WR, a, d, 0, 1'b0, 3'h0);
	endfunction

	function automatic logic [15:0] ctrl0_val(input logic run, input logic [2:0] period);
		ctrl0_val = (16'(run) << CCT_CTRL0_RUN) | (16'(!twelve_hour) << CCT_CTRL0_HOUR24)
			| 16'(period);
	endfunction

	// writing zero to the flag bits clears them
	function automatic logic [15:0] ctrl1_val(input logic en, input logic req);
		ctrl1_val = (16'(en) << CCT_CTRL1_ALARM_EN) | (16'(req) << CCT_CTRL1_HOLD_REQ);
	endfunction

	function automatic logic [15:0] bit_val(input int b);
		bit_val = 16'h0001 << b;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// per-command sequences
	function automatic cct_op_t seq_op(input cct_cmd_t c, input logic [5:0] s);
		logic [2:0] slot;
		slot = 3'(s - 6'd4);
		seq_op = op_mk(CCT_OP_END, 20'h00000, 16'h0000, 0, 1'b0, 3'h0);
		unique case (c)
			CCT_CMD_START:
			begin
				unique case (s)
					6'd0: seq_op = op_wr(CCT_ADDR_UNLOCK, bit_val(CCT_UNLOCK_BIT));
					6'd1: seq_op = op_wr(CCT_ADDR_CTRL0, ctrl0_val(1'b0, CCT_PERIOD_OFF));
					6'd2: seq_op = op_mk(CCT_OP_WAIT, 20'h00000, 16'h0000, 0, 1'b0, 3'h0);
					6'd3: seq_op = op_wr(CCT_ADDR_CTRL0, ctrl0_val(1'b0, CCT_PERIOD_OFF));
					6'd4, 6'd5, 6'd6, 6'd7, 6'd8, 6'd9, 6'd10:
						seq_op = op_wr(CCT_ADDR_SEC + 20'(slot), 16'(time_in[{slot, 3'b000} +: 8]));
					6'd11: seq_op = op_wr(CCT_ADDR_TRIM,
						{trim_on, 6'h00, trim_ppm_code + CCT_TRIM_ZERO});
					6'd12: seq_op = op_wr(CCT_ADDR_IRQ_FLAG, 16'h0000);
					6'd13: seq_op = op_wr(CCT_ADDR_IRQ_MASK, 16'h0000);
					6'd14: seq_op = op_wr(CCT_ADDR_CTRL0, ctrl0_val(1'b1, CCT_PERIOD_OFF));
					6'd15: seq_op = op_mk(CCT_OP_WAIT, 20'h00000, 16'h0000, 0, 1'b0, 3'h0);
					6'd16: seq_op = op_wr(CCT_ADDR_UNLOCK, 16'h0000);
					default: ;
				endcase
			end
			CCT_CMD_READ:
			begin
				unique case (s)
					6'd0: seq_op = op_wr(CCT_ADDR_UNLOCK, bit_val(CCT_UNLOCK_BIT));
					6'd1: seq_op = op_wr(CCT_ADDR_IRQ_MASK, bit_val(CCT_IRQ_TICK));
					6'd2: seq_op = op_wr(CCT_ADDR_CTRL0, ctrl0_val(1'b1, CCT_PERIOD_1S));
					6'd3: seq_op = op_wr(CCT_ADDR_CTRL1, ctrl1_val(r.alarm_armed, 1'b0));
					6'd4: seq_op = op_wr(CCT_ADDR_IRQ_FLAG, 16'h0000);
					6'd5: seq_op = op_wr(CCT_ADDR_IRQ_MASK, 16'h0000);
					6'd6: seq_op = op_mk(CCT_OP_POLL, CCT_ADDR_IRQ_FLAG, 16'h0000,
						CCT_IRQ_TICK, 1'b1, 3'h0);
					6'd7: seq_op = op_mk(CCT_OP_RD_FLAG, CCT_ADDR_CTRL1, 16'h0000,
						CCT_CTRL1_ALARM_FLAG, 1'b0, 3'h0);
					6'd8: seq_op = op_wr(CCT_ADDR_IRQ_MASK, bit_val(CCT_IRQ_TICK));
					6'd9: seq_op = op_wr(CCT_ADDR_CTRL1, ctrl1_val(r.alarm_armed, 1'b1));
					6'd10: seq_op = op_mk(CCT_OP_POLL, CCT_ADDR_CTRL1, 16'h0000,
						CCT_CTRL1_HOLD_ACK, 1'b1, 3'h0);
					6'd11, 6'd12, 6'd13, 6'd14, 6'd15, 6'd16, 6'd17:
						seq_op = op_mk(CCT_OP_RD_TIME, CCT_ADDR_SEC + 20'(3'(s - 6'd11)),
							16'h0000, 0, 1'b0, 3'(s - 6'd11));
					6'd18: seq_op = op_wr(CCT_ADDR_CTRL1, ctrl1_val(r.alarm_armed, 1'b0));
					6'd19: seq_op = op_mk(CCT_OP_POLL, CCT_ADDR_CTRL1, 16'h0000,
						CCT_CTRL1_HOLD_ACK, 1'b0, 3'h0);
					6'd20: seq_op = op_wr(CCT_ADDR_CTRL0, ctrl0_val(1'b1, CCT_PERIOD_OFF));
					6'd21: seq_op = op_wr(CCT_ADDR_CTRL1, ctrl1_val(r.alarm_armed, 1'b0));
					6'd22: seq_op = op_wr(CCT_ADDR_IRQ_FLAG, 16'h0000);
					6'd23: seq_op = op_wr(CCT_ADDR_IRQ_MASK, 16'h0000);
					6'd24: seq_op = op_wr(CCT_ADDR_UNLOCK, 16'h0000);
					default: ;
				endcase
			end
			CCT_CMD_ALARM:
			begin
				unique case (s)
					6'd0: seq_op = op_wr(CCT_ADDR_UNLOCK, bit_val(CCT_UNLOCK_BIT));
					6'd1: seq_op = op_wr(CCT_ADDR_CTRL1, ctrl1_val(1'b0, 1'b0));
					6'd2: seq_op = op_wr(CCT_ADDR_ALARM_MIN, 16'(alarm_minute));
					6'd3: seq_op = op_wr(CCT_ADDR_ALARM_HOUR, 16'(alarm_hour));
					6'd4: seq_op = op_wr(CCT_ADDR_ALARM_WEEK, 16'(alarm_weekdays));
					6'd5: seq_op = op_wr(CCT_ADDR_CTRL1, ctrl1_val(1'b1, 1'b0));
					6'd6: seq_op = op_mk(CCT_OP_WAIT, 20'h00000, 16'h0000, 0, 1'b0, 3'h0);
					6'd7: seq_op = op_wr(CCT_ADDR_UNLOCK, 16'h0000);
					default: ;
				endcase
			end
			CCT_CMD_TRIM:
			begin
				unique case (s)
					6'd0: seq_op = op_wr(CCT_ADDR_UNLOCK, bit_val(CCT_UNLOCK_BIT));
					6'd1: seq_op = op_wr(CCT_ADDR_TRIM,
						{trim_on, 6'h00, trim_ppm_code + CCT_TRIM_ZERO});
					6'd2: seq_op = op_wr(CCT_ADDR_UNLOCK, 16'h0000);
					default: ;
				endcase
			end
			CCT_CMD_STOP_PREP:
			begin
				if (s == 6'd0)
					seq_op = op_mk(CCT_OP_POLL, CCT_ADDR_CTRL1, 16'h0000,
						CCT_CTRL1_HOLD_ACK, 1'b0, 3'h0);
			end
			default: ;
		endcase
	endfunction

	// always_comb so that the user inputs read inside seq_op are in the sensitivity
	always_comb
		op = seq_op(r.cmd, r.step);

	////////////////////////////////////////////////////////////////////////////////
	// sequencer
	always_comb
	begin
		next_r = r;
		next_r.done = 1'b0;
		if (r.holding)
			next_r.hold_cnt = r.hold_cnt + 28'd1;
		unique case (r.state)
			CCT_ST_IDLE:
			begin
				if (cmd_valid && cmd_code >= 3'(CCT_CMD_START) && cmd_code <= 3'(CCT_CMD_STOP_PREP))
				begin
					if (cct_cmd_t'(cmd_code) == CCT_CMD_ALARM && !alarm_ok)
					begin
						// out-of-range alarm would never match: refuse it
						next_r.done = 1'b1;
						next_r.error = 1'b1;
					end
					else
					begin
						next_r.cmd = cct_cmd_t'(cmd_code);
						// with the counter stopped no acknowledge will come, read directly
						next_r.step = (cct_cmd_t'(cmd_code) == CCT_CMD_READ && !r.running) ?
							READ_FIRST_TIME : 6'd0;
						next_r.busy = 1'b1;
						next_r.error = 1'b0;
						next_r.stop_safe = 1'b0;
						next_r.state = CCT_ST_ISSUE;
						if (cct_cmd_t'(cmd_code) == CCT_CMD_ALARM)
							next_r.alarm_armed = 1'b1;
					end
				end
			end
			CCT_ST_ISSUE:
			begin
				if (r.holding && r.hold_cnt >= 28'(HOLD_MAX_CYC) && r.step < READ_RELEASE)
				begin
					next_r.step = READ_RELEASE;
					next_r.error = 1'b1;
				end
				else
				begin
					unique case (op.kind)
						CCT_OP_WR:
						begin
							next_r.dev_addr = op.addr;
							next_r.dev_wdata = op.data;
							next_r.dev_wr = 1'b1;
							next_r.state = CCT_ST_BUS;
						end
						CCT_OP_POLL, CCT_OP_RD_TIME, CCT_OP_RD_FLAG:
						begin
							next_r.dev_addr = op.addr;
							next_r.dev_rd = 1'b1;
							next_r.state = CCT_ST_BUS;
						end
						CCT_OP_WAIT:
						begin
							next_r.wait_cnt = 28'(SUBCLK_WAIT_CYC - 1);
							next_r.state = CCT_ST_WAIT;
						end
						CCT_OP_END:
						begin
							next_r.busy = 1'b0;
							next_r.done = 1'b1;
							next_r.stop_safe = 1'b1;
							next_r.state = CCT_ST_IDLE;
							if (r.cmd == CCT_CMD_START)
								next_r.running = 1'b1;
						end
						default: next_r.state = CCT_ST_IDLE;
					endcase
				end
			end
			CCT_ST_BUS:
			begin
				if (dev_ack)
				begin
					next_r.dev_wr = 1'b0;
					next_r.dev_rd = 1'b0;
					next_r.state = CCT_ST_ISSUE;
					next_r.step = r.step + 6'd1;
					unique case (op.kind)
						CCT_OP_POLL:
							if (dev_rdata[op.bit_sel] != op.bit_val)
								next_r.step = r.step;
						CCT_OP_RD_TIME:
							next_r.time_out[{op.slot, 3'b000} +: 8] = dev_rdata[7:0];
						CCT_OP_RD_FLAG:
							next_r.alarm_hit = dev_rdata[op.bit_sel];
						default: ;
					endcase
					if (r.cmd == CCT_CMD_READ && r.step == READ_HOLD)
					begin
						next_r.holding = 1'b1;
						next_r.hold_cnt = 28'd0;
					end
					if (r.cmd == CCT_CMD_READ && r.step == READ_RELEASE)
						next_r.holding = 1'b0;
					if (r.cmd == CCT_CMD_READ && r.step == READ_LAST_TIME && !r.running)
						next_r.step = READ_LOCK;
				end
			end
			CCT_ST_WAIT:
			begin
				if (r.wait_cnt == 28'd0)
				begin
					next_r.step = r.step + 6'd1;
					next_r.state = CCT_ST_ISSUE;
				end
				else
					next_r.wait_cnt = r.wait_cnt - 28'd1;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			r <= '0;
		else
			r <= next_r;
	end

	assign busy = r.busy;
	assign done = r.done;
	assign error = r.error;
	assign alarm_hit = r.alarm_hit;
	assign stop_safe = r.stop_safe;
	assign time_out = r.time_out;
	assign dev_addr = r.dev_addr;
	assign dev_wdata = r.dev_wdata;
	assign dev_wr = r.dev_wr;
	assign dev_rd = r.dev_rd;

endmodule
`default_nettype wire

// >>> hw/cct_pkg.sv
package cct_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// device register map
	localparam logic [19:0] CCT_ADDR_TRIM = 20'hf0310;
	localparam logic [19:0] CCT_ADDR_SEC = 20'hfff92;
	localparam logic [19:0] CCT_ADDR_ALARM_MIN = 20'hfff9a;
	localparam logic [19:0] CCT_ADDR_ALARM_HOUR = 20'hfff9b;
	localparam logic [19:0] CCT_ADDR_ALARM_WEEK = 20'hfff9c;
	localparam logic [19:0] CCT_ADDR_CTRL0 = 20'hfff9d;
	localparam logic [19:0] CCT_ADDR_CTRL1 = 20'hfff9e;
	localparam logic [19:0] CCT_ADDR_UNLOCK = 20'hf00f0;
	localparam logic [19:0] CCT_ADDR_IRQ_FLAG = 20'hfffe0;
	localparam logic [19:0] CCT_ADDR_IRQ_MASK = 20'hfffe4;

	////////////////////////////////////////////////////////////////////////////////
	// field positions and values
	localparam int CCT_CTRL0_RUN = 7;
	localparam int CCT_CTRL0_HOUR24 = 3;
	localparam int CCT_CTRL1_ALARM_EN = 7;
	localparam int CCT_CTRL1_ALARM_FLAG = 4;
	localparam int CCT_CTRL1_FIXED_FLAG = 3;
	localparam int CCT_CTRL1_HOLD_ACK = 1;
	localparam int CCT_CTRL1_HOLD_REQ = 0;
	localparam int CCT_UNLOCK_BIT = 0;
	localparam int CCT_IRQ_TICK = 0;
	localparam int CCT_IRQ_TRIM = 1;
	localparam int CCT_TRIM_ON = 15;
	localparam logic [15:0] CCT_TRIM_RESET = 16'h0020;
	localparam logic [8:0] CCT_TRIM_ZERO = 9'h020;
	localparam logic [2:0] CCT_PERIOD_1S = 3'h2;
	localparam logic [2:0] CCT_PERIOD_OFF = 3'h0;

	////////////////////////////////////////////////////////////////////////////////
	// timing
	localparam longint CCT_CLK_PS = 4000;
	localparam longint CCT_SUBCLK_HZ = 32768;
	localparam longint CCT_SUBCLK_WAIT_N = 2;
	localparam longint CCT_HOLD_MAX_S = 1;
	localparam longint CCT_PS_PER_S = 64'd1000000000000;
	localparam int CCT_SUBCLK_WAIT_CYC = int'((CCT_SUBCLK_WAIT_N * CCT_PS_PER_S
		+ CCT_SUBCLK_HZ * CCT_CLK_PS - 1) / (CCT_SUBCLK_HZ * CCT_CLK_PS));
	localparam int CCT_HOLD_MAX_CYC = int'(CCT_HOLD_MAX_S * CCT_PS_PER_S / CCT_CLK_PS);

	////////////////////////////////////////////////////////////////////////////////
	// commands, states, sequencer operations
	typedef enum logic [2:0] {
		CCT_CMD_NONE = 3'h0,
		CCT_CMD_START = 3'h1,
		CCT_CMD_READ = 3'h2,
		CCT_CMD_ALARM = 3'h3,
		CCT_CMD_TRIM = 3'h4,
		CCT_CMD_STOP_PREP = 3'h5
	} cct_cmd_t;

	typedef enum logic [1:0] {
		CCT_ST_IDLE = 2'b00,
		CCT_ST_ISSUE = 2'b01,
		CCT_ST_BUS = 2'b11,
		CCT_ST_WAIT = 2'b10
	} cct_state_t;

	typedef enum logic [2:0] {
		CCT_OP_WR = 3'h0,
		CCT_OP_POLL = 3'h1,
		CCT_OP_RD_TIME = 3'h2,
		CCT_OP_RD_FLAG = 3'h3,
		CCT_OP_WAIT = 3'h4,
		CCT_OP_END = 3'h5
	} cct_opk_t;

	typedef struct packed {
		cct_opk_t kind;
		logic [19:0] addr;
		logic [15:0] data;
		logic [3:0] bit_sel;
		logic bit_val;
		logic [2:0] slot;
	} cct_op_t;

endpackage

// >>> hw/cct_alarm_check.sv
`timescale 1ns/1ps
`default_nettype none

module cct_alarm_check
	import cct_pkg::*;
(
	// alarm values to be written
	input wire logic [7:0] alarm_minute,
	input wire logic [7:0] alarm_hour,
	input wire logic [7:0] alarm_weekdays,
	input wire logic twelve_hour,
	// verdict
	output logic alarm_ok
);

	function automatic logic bcd_in(input logic [7:0] v, input logic [7:0] lo,
		input logic [7:0] hi);
		bcd_in = (v[3:0] <= 4'h9) && (v >= lo) && (v <= hi);
	endfunction

	logic minute_ok;
	logic hour_ok;

	assign minute_ok = bcd_in(alarm_minute, 8'h00, 8'h59);
	// pm hours carry bit 5, so 21..32 is the pm half of the 12-hour range
	assign hour_ok = twelve_hour ?
		(bcd_in(alarm_hour, 8'h01, 8'h12) || bcd_in(alarm_hour, 8'h21, 8'h32)) :
		bcd_in(alarm_hour, 8'h00, 8'h23);
	assign alarm_ok = minute_ok && hour_ok && !alarm_weekdays[7];

endmodule
`default_nettype wire

// >>> tb/cct_host_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cct_host_asserts
	import cct_pkg::*;
#(
	parameter int HOLD_MAX_CYC = CCT_HOLD_MAX_CYC
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// user side
	input wire logic cmd_valid,
	input wire logic [2:0] cmd_code,
	input wire logic twelve_hour,
	input wire logic trim_on,
	input wire logic [8:0] trim_ppm_code,
	input wire logic busy,
	input wire logic done,
	input wire logic stop_safe,
	// device side
	input wire logic [19:0] dev_addr,
	input wire logic [15:0] dev_wdata,
	input wire logic dev_wr,
	input wire logic dev_rd,
	input wire logic dev_ack
);
	logic [31:0] hold_cnt;
	logic unlock_on;
	logic wr_done;
	assign wr_done = dev_wr && dev_ack;
	// cycles since hold was requested, and last unlock value written
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			hold_cnt <= 32'h0;
			unlock_on <= 1'b0;
		end
		else
		begin
			if (wr_done && dev_addr == CCT_ADDR_CTRL1)
				hold_cnt <= dev_wdata[CCT_CTRL1_HOLD_REQ] ? 32'h1 : 32'h0;
			else if (hold_cnt != 32'h0)
				hold_cnt <= hold_cnt + 32'h1;
			if (wr_done && dev_addr == CCT_ADDR_UNLOCK)
				unlock_on <= dev_wdata[CCT_UNLOCK_BIT];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_hold;
		(dev_wr || dev_rd) && !dev_ack |=> $stable({dev_wr, dev_rd, dev_addr, dev_wdata});
	endproperty
	a_hold: assert property (p_hold) else $error("bus request changed before ack");
	property p_drop; (dev_wr || dev_rd) && dev_ack |=> !dev_wr && !dev_rd; endproperty
	a_drop: assert property (p_drop) else $error("strobe kept after ack");
	property p_done; $fell(busy) |-> done ##1 !done; endproperty
	a_done: assert property (p_done) else $error("done not a pulse at end of busy");
	property p_accept;
		!busy && !done && cmd_valid && cmd_code inside {[3'h1:3'h5]} |=> ##[0:1] (busy || done);
	endproperty
	a_accept: assert property (p_accept) else $error("command not taken");
	property p_trim;
		dev_wr && dev_addr == CCT_ADDR_TRIM |->
			dev_wdata == {trim_on, 6'h0, trim_ppm_code + CCT_TRIM_ZERO};
	endproperty
	a_trim: assert property (p_trim) else $error("trim word wrong");
	property p_min;
		dev_wr && dev_addr == CCT_ADDR_ALARM_MIN |->
			dev_wdata[7:0] <= 8'h59 && dev_wdata[3:0] <= 4'h9;
	endproperty
	a_min: assert property (p_min) else $error("bad alarm minute written");
	property p_hour;
		dev_wr && dev_addr == CCT_ADDR_ALARM_HOUR |-> dev_wdata[3:0] <= 4'h9 && (twelve_hour ?
			dev_wdata[7:0] inside {[8'h01:8'h12], [8'h21:8'h32]} : dev_wdata[7:0] <= 8'h23);
	endproperty
	a_hour: assert property (p_hour) else $error("bad alarm hour written");
	property p_week; dev_wr && dev_addr == CCT_ADDR_ALARM_WEEK |-> !dev_wdata[7]; endproperty
	a_week: assert property (p_week) else $error("alarm weekday bit 7 set");
	property p_hold_max; hold_cnt != 32'h0 |-> hold_cnt <= HOLD_MAX_CYC + 64; endproperty
	a_hold_max: assert property (p_hold_max) else $error("hold kept too long");
	property p_stop; stop_safe |-> hold_cnt == 32'h0 && !busy; endproperty
	a_stop: assert property (p_stop) else $error("stop allowed during hold");
	property p_unlock; $fell(busy) |-> !unlock_on; endproperty
	a_unlock: assert property (p_unlock) else $error("unlock left set");
endmodule
bind cct_host cct_host_asserts #(.HOLD_MAX_CYC(HOLD_MAX_CYC)) i_cct_host_asserts (.clk(clk),
	.rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .twelve_hour(twelve_hour),
	.trim_on(trim_on), .trim_ppm_code(trim_ppm_code), .busy(busy), .done(done),
	.stop_safe(stop_safe),
	.dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd),
	.dev_ack(dev_ack));
`default_nettype wire

// >>> tb/cct_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module cct_dev_model
	import cct_pkg::*;
(
	// clock, resets, pacing
	input wire logic clk,
	input wire logic rst_b,
	input wire logic por_b,
	input wire logic slow,
	// register access
	input wire logic [19:0] dev_addr,
	input wire logic [15:0] dev_wdata,
	input wire logic dev_wr,
	input wire logic dev_rd,
	output logic [15:0] dev_rdata,
	output logic dev_ack
);
	logic [15:0] trim, rval, last;
	logic [7:0] alm_min, alm_hour, alm_week, ctrl0, ctrl1;
	logic [7:0] cnt [7];
	logic [1:0] iflag, imask;
	logic unlock, hold_ack;
	logic [2:0] wait_n;
	logic [4:0] tick_n;
	logic [19:0] idx;
	assign idx = dev_addr - CCT_ADDR_SEC;
	always_comb
	begin
		rval = 16'h0;
		case (dev_addr)
			CCT_ADDR_TRIM: rval = trim;
			CCT_ADDR_CTRL0: rval = {8'h0, ctrl0};
			CCT_ADDR_CTRL1: rval = {8'h0, ctrl1[7:2], hold_ack, ctrl1[0]};
			CCT_ADDR_IRQ_FLAG: rval = {14'h0, iflag};
			default: if (idx < 20'h7) rval = {8'h0, cnt[idx]};
		endcase
	end
	// an idle data bus never repeats the last answer
	assign dev_rdata = dev_ack ? rval : ~last;
	always @(posedge clk or negedge rst_b)
		if (!rst_b)
		begin
			dev_ack <= 1'b0;
			wait_n <= 3'h0;
		end
		else if ((dev_wr || dev_rd) && !dev_ack)
		begin
			wait_n <= wait_n + 3'h1;
			dev_ack <= (wait_n + 3'h1) >= (slow ? 3'h3 : 3'h1);
		end
		else
		begin
			dev_ack <= 1'b0;
			wait_n <= 3'h0;
		end
	always @(posedge clk or negedge por_b)
		if (!por_b)
			trim <= CCT_TRIM_RESET;
		else if (dev_ack && dev_wr && dev_addr == CCT_ADDR_TRIM)
			trim <= {dev_wdata[15], 6'h0, dev_wdata[8:0]};
	// alarm registers have no reset at all
	always @(posedge clk)
		if (!por_b)
		begin
			{ctrl0, ctrl1, iflag, imask, unlock, tick_n} <= '0;
		end
		else
		begin
			if (dev_ack)
				last <= rval;
			hold_ack <= ctrl0[7] && ctrl1[0];
			tick_n <= (ctrl0[7] && ctrl0[2:0] == CCT_PERIOD_1S) ? tick_n + 5'h1 : 5'h0;
			if (tick_n == 5'd19)
			begin
				iflag[0] <= 1'b1;
				ctrl1[3] <= 1'b1;
				// once-a-second correction timing while trim is enabled
				if (trim[15])
					iflag[1] <= 1'b1;
				if (ctrl1[7] && alm_min == cnt[1] && alm_hour == cnt[2] && alm_week[cnt[3][2:0]])
					ctrl1[4] <= 1'b1;
			end
			if (dev_ack && dev_wr)
				case (dev_addr)
					CCT_ADDR_ALARM_MIN: alm_min <= dev_wdata[7:0];
					CCT_ADDR_ALARM_HOUR: alm_hour <= dev_wdata[7:0];
					CCT_ADDR_ALARM_WEEK: alm_week <= dev_wdata[7:0];
					CCT_ADDR_CTRL0: ctrl0 <= dev_wdata[7:0];
					CCT_ADDR_CTRL1: ctrl1 <= dev_wdata[7:0];
					CCT_ADDR_UNLOCK: unlock <= dev_wdata[0];
					CCT_ADDR_IRQ_FLAG: iflag <= dev_wdata[1:0];
					CCT_ADDR_IRQ_MASK: imask <= dev_wdata[1:0];
					default: if (idx < 20'h7) cnt[idx] <= dev_wdata[7:0];
				endcase
		end
endmodule
`default_nettype wire

// >>> tb/test_calendar_clock_trim_alarm.sv
`timescale 1ns/1ps
`default_nettype none
module test_calendar_clock_trim_alarm
	import cct_pkg::*;
;
	logic clk, rst_b, por_b, slow, cmd_valid, twelve_hour, trim_on;
	logic busy, done, error, alarm_hit, stop_safe, dev_wr, dev_rd, dev_ack;
	logic [2:0] cmd_code;
	logic [55:0] time_in, time_out;
	logic [7:0] a_min, a_hour, a_week, e_min, e_hour, e_week;
	logic [8:0] trim_code;
	logic [19:0] dev_addr;
	logic [15:0] dev_wdata, dev_rdata;
	int failures, compares;
	// enable, code, expected register
	logic [25:0] trim_tab [5] = '{{1'b0, 9'h000, 16'h0020}, {1'b1, 9'h1ed, 16'h800d},
		{1'b1, 9'h013, 16'h8033}, {1'b1, 9'h0e0, 16'h8100}, {1'b1, 9'h0df, 16'h80ff}};
	// twelve-hour, minute, hour, weekdays, accepted
	logic [25:0] alm_tab [11] = '{{1'b0, 24'h59237f, 1'b1}, {1'b0, 24'h60237f, 1'b0},
		{1'b0, 24'h5a1001, 1'b0}, {1'b0, 24'h302401, 1'b0}, {1'b1, 24'h303201, 1'b1},
		{1'b1, 24'h301201, 1'b1}, {1'b1, 24'h301301, 1'b0}, {1'b1, 24'h300001, 1'b0},
		{1'b1, 24'h302101, 1'b1}, {1'b1, 24'h302001, 1'b0}, {1'b0, 24'h000080, 1'b0}};
	cct_host #(.SUBCLK_WAIT_CYC(4), .HOLD_MAX_CYC(200)) i_cct_host (.clk(clk), .rst_b(rst_b),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .twelve_hour(twelve_hour),
		.time_in(time_in), .alarm_minute(a_min), .alarm_hour(a_hour),
		.alarm_weekdays(a_week), .trim_on(trim_on), .trim_ppm_code(trim_code), .busy(busy),
		.done(done), .error(error), .alarm_hit(alarm_hit), .stop_safe(stop_safe),
		.time_out(time_out), .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr(dev_wr),
		.dev_rd(dev_rd), .dev_rdata(dev_rdata), .dev_ack(dev_ack));
	cct_dev_model i_cct_dev_model (.clk(clk), .rst_b(rst_b), .por_b(por_b), .slow(slow),
		.dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd),
		.dev_rdata(dev_rdata), .dev_ack(dev_ack));
	////////////////////////////////////////////////////////////////////////////////
	task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
		compares++;
		if (g !== e)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cmd(input logic [2:0] c);
		int n;
		@(negedge clk);
		cmd_code = c;
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 4000)
		begin
			@(negedge clk);
			n++;
		end
		cmp("done", 64'h1, done);
	endtask
	task automatic close_out();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial
	begin
		#200000;
		failures++;
		close_out();
	end
	initial
	begin
		{rst_b, por_b, slow, cmd_valid, cmd_code, twelve_hour, trim_on, trim_code} = '0;
		{a_min, a_hour, a_week} = '0;
		time_in = 56'h23123106235958;
		failures = 0;
		compares = 0;
		repeat (2) @(negedge clk);
		{rst_b, por_b} = 2'b11;
		cmp("trim reset", 64'h0020, i_cct_dev_model.trim);
		cmp("busy reset", 64'h0, busy);
		for (int i = 0; i < 5; i++)
		begin
			{trim_on, trim_code} = trim_tab[i][25:16];
			cmd(CCT_CMD_TRIM);
			cmp("trim", trim_tab[i][15:0], i_cct_dev_model.trim);
			cmp("unlock", 64'h0, i_cct_dev_model.unlock);
		end
		$display("test trim done");
		for (int i = 0; i < 11; i++)
		begin
			{twelve_hour, a_min, a_hour, a_week} = alm_tab[i][25:1];
			cmd(CCT_CMD_ALARM);
			cmp("alarm error", !alm_tab[i][0], error);
			if (alm_tab[i][0])
				{e_min, e_hour, e_week} = {a_min, a_hour, a_week};
			cmp("alarm regs", {e_min, e_hour, e_week}, {i_cct_dev_model.alm_min,
				i_cct_dev_model.alm_hour, i_cct_dev_model.alm_week});
		end
		$display("test alarm values done");
		twelve_hour = 1'b0;
		{trim_on, trim_code} = trim_tab[2][25:16];
		cmd(CCT_CMD_START);
		cmp("run and 24h", 64'h88, i_cct_dev_model.ctrl0 & 8'h88);
		cmp("irq cleared", 64'h0, {i_cct_dev_model.iflag, i_cct_dev_model.imask});
		cmp("trim at start", 64'h8033, i_cct_dev_model.trim);
		for (int i = 0; i < 7; i++)
			cmp("counter", time_in[8*i+:8], i_cct_dev_model.cnt[i]);
		$display("test start done");
		for (int i = 0; i < 2; i++)
		begin
			{a_min, a_hour, a_week} = {16'h5923, i ? 8'h3f : 8'h40};
			slow = i[0];
			cmd(CCT_CMD_ALARM);
			cmd(CCT_CMD_READ);
			cmp("alarm hit", !i[0], alarm_hit);
			cmp("time out", time_in, time_out);
			cmp("hold ack", 64'h0, i_cct_dev_model.hold_ack);
			cmp("period", 64'h0, i_cct_dev_model.ctrl0[2:0]);
			cmp("read error", 64'h0, error);
		end
		$display("test read done");
		cmd(CCT_CMD_STOP_PREP);
		cmp("stop safe", 64'h1, stop_safe);
		rst_b = 1'b0;
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		cmp("busy", 64'h0, busy);
		cmp("kept regs", 64'h59233f8033, {i_cct_dev_model.alm_min, i_cct_dev_model.alm_hour,
			i_cct_dev_model.alm_week, i_cct_dev_model.trim});
		cmd(CCT_CMD_READ);
		cmp("time after reset", time_in, time_out);
		$display("test reset done");
		close_out();
	end
endmodule
`default_nettype wire
